// File: common/interp_buf_regs.svh
`ifndef INTERP_BUF_REGS_SVH
`define INTERP_BUF_REGS_SVH

// ==========================================================
// object indices
`define IDX_CTRL_WORD 16'h6040
`define IDX_CFG_FIRST 16'h2730
`define IDX_CFG_SECOND 16'h2731
`define IDX_PROFILE_SEL 16'h2732
`define IDX_REC_FIRST 16'h27c0
`define IDX_REC_SECOND 16'h27c1
`define IDX_PTR_MON 16'h2741

// ==========================================================
// sub-indices and bit positions
`define SUB_CFG_COUNT 8'h00
`define SUB_CFG_MAX_SIZE 8'h01
`define SUB_CFG_ACT_SIZE 8'h02
`define SUB_CFG_ORG 8'h03
`define SUB_CFG_DEF 8'h07
`define SUB_CFG_POL 8'h08
`define SUB_CFG_EOB 8'h09
`define SUB_PTR_READ 8'h01
`define SUB_PTR_WRITE 8'h02
`define BIT_ENABLE_INTERP 4

// ==========================================================
// fixed values and reset values
`define CFG_ENTRY_COUNT 32'h0000_0009
`define PTR_ENTRY_COUNT 32'h0000_0002
`define RECORD_LEN 8'hfe
`define PTR_INIT 8'h01
`define SEL_RESET 1'b0
`define CFG_FIRST_RESET 4'h4
`define CFG_SECOND_RESET 4'h0

`endif

// File: common/interp_buf_pkg.sv
package interp_buf_pkg;

    // organisation, definition, polarity, end-of-buffer behaviour
    typedef struct packed {
        logic org;
        logic def;
        logic pol;
        logic eob;
    } buf_cfg_t;

    typedef enum logic {
        ORG_FIFO,
        ORG_RING
    } buf_org_t;

    typedef enum {
        M_IDLE,
        M_WAIT,
        M_REFUSE
    } master_state_t;

endpackage : interp_buf_pkg

// File: common/od_link_if.sv
`timescale 1ns/1ps
interface od_link_if;
    logic req;
    logic we;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] wdata;
    logic ack;
    logic err;
    logic [31:0] rdata;

    modport device (
        input req,
        input we,
        input index,
        input sub,
        input wdata,
        output ack,
        output err,
        output rdata
    );

    modport master (
        output req,
        output we,
        output index,
        output sub,
        output wdata,
        input ack,
        input err,
        input rdata
    );
endinterface : od_link_if

// File: src/setpoint_ram.sv
`timescale 1ns/1ps
module setpoint_ram #(
    parameter int AW = 9
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [31:0] wdata,
    input wire logic [AW-1:0] raddr_a,
    output logic [31:0] rdata_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [31:0] rdata_b
);
    logic [31:0] mem_r [0:(1<<AW)-1];

    // ==========================================================
    // storage, every entry cleared by reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < (1<<AW); i++) begin
                mem_r[i] <= 32'h0000_0000;
            end
        end else if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    assign rdata_a = mem_r[raddr_a];
    assign rdata_b = mem_r[raddr_b];
endmodule : setpoint_ram

// File: src/interp_buffer_device.sv
`timescale 1ns/1ps
`include "interp_buf_regs.svh"

// Notes on behaviour
// - definition 0 absolute, 1 relative
// - polarity 1 negates the set point
// - polarity only matters in relative mode
// - definition/polarity writable only when pointers equal
// - fifo, eob 0, idle at end: hold
// - fifo, eob 1, idle at end: reinitialise
// - end behaviour ignored unless fifo
// - selector picks profile record and configuration
// - master changes selector only when disabled
// - 254 signed entries, sub 0 reads count
// - master writes configuration before record
// - master sets enable bit after record; the master end does not check this
// - organisation 0 fifo, 1 ring
// - read and write pointers read-only, 1..254
module interp_buffer_device
    import interp_buf_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    od_link_if.device link,
    input wire logic cycle_tick,
    output logic [31:0] pos_ref,
    output logic pos_strobe,
    output logic interp_enabled,
    output logic [7:0] read_ptr,
    output logic [7:0] write_ptr
);
    logic sel_r;
    logic sel_nxt;
    buf_cfg_t cfg_r [0:1];
    buf_cfg_t cfg_nxt [0:1];
    logic enable_r;
    logic enable_nxt;
    logic [7:0] rd_r;
    logic [7:0] rd_nxt;
    logic [7:0] wr_r;
    logic [7:0] wr_nxt;
    logic [31:0] pos_r;
    logic [31:0] pos_nxt;
    logic stb_r;
    logic stb_nxt;
    logic ack_r;
    logic ack_nxt;
    logic err_r;
    logic err_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    logic take;
    logic bank;
    logic sub_in_record;
    logic ptr_equal;
    logic mem_we;
    logic [31:0] od_word;
    logic [31:0] run_word;
    buf_cfg_t act_cfg;

    // ==========================================================
    // set-point storage, both profiles
    setpoint_ram #(
        .AW(9)
    ) u_ram (
        .clk(clk),
        .reset(reset),
        .we(mem_we),
        .waddr({bank, link.sub}),
        .wdata(link.wdata),
        .raddr_a({bank, link.sub}),
        .rdata_a(od_word),
        .raddr_b({sel_r, rd_r}),
        .rdata_b(run_word)
    );

    assign take = link.req && !ack_r;
    assign bank = link.index[0];
    assign sub_in_record = (link.sub != 8'h00) && (link.sub <= `RECORD_LEN);
    assign ptr_equal = (rd_r == wr_r);
    assign act_cfg = cfg_r[sel_r];

    // ==========================================================
    // next-state logic
    always_comb begin
        sel_nxt = sel_r;
        cfg_nxt[0] = cfg_r[0];
        cfg_nxt[1] = cfg_r[1];
        enable_nxt = enable_r;
        rd_nxt = rd_r;
        wr_nxt = wr_r;
        pos_nxt = pos_r;
        stb_nxt = 1'b0;
        ack_nxt = take;
        err_nxt = 1'b0;
        rdata_nxt = 32'h0000_0000;
        mem_we = 1'b0;

        // consumption of buffered set points
        if (enable_r && cycle_tick && !ptr_equal) begin
            if (act_cfg.def) begin
                if (act_cfg.pol) begin
                    pos_nxt = pos_r - run_word;
                end else begin
                    pos_nxt = pos_r + run_word;
                end
            end else begin
                pos_nxt = run_word;
            end
            stb_nxt = 1'b1;
            rd_nxt = (rd_r == `RECORD_LEN) ? `PTR_INIT : rd_r + 8'h01;
        end else if (ptr_equal) begin
            if (act_cfg.org == ORG_RING) begin
                if (enable_r && cycle_tick && wr_r != `PTR_INIT) begin
                    rd_nxt = `PTR_INIT;
                end
            end else if (!enable_r && act_cfg.eob) begin
                rd_nxt = `PTR_INIT;
            end
            // eob 0 leaves the read pointer where it is
        end

        // object dictionary access
        if (take) begin
            case (link.index)
                `IDX_CTRL_WORD: begin
                    if (link.we) begin
                        enable_nxt = link.wdata[`BIT_ENABLE_INTERP];
                    end
                    rdata_nxt[`BIT_ENABLE_INTERP] = enable_r;
                end
                `IDX_PROFILE_SEL: begin
                    if (link.we) begin
                        if (link.wdata[31:1] != 31'h0000_0000) begin
                            err_nxt = 1'b1;
                        end else begin
                            sel_nxt = link.wdata[0];
                        end
                    end
                    rdata_nxt[0] = sel_r;
                end
                `IDX_CFG_FIRST, `IDX_CFG_SECOND: begin
                    case (link.sub)
                        `SUB_CFG_COUNT: begin
                            err_nxt = link.we;
                            rdata_nxt = `CFG_ENTRY_COUNT;
                        end
                        `SUB_CFG_MAX_SIZE, `SUB_CFG_ACT_SIZE: begin
                            err_nxt = link.we;
                            rdata_nxt[7:0] = `RECORD_LEN;
                        end
                        `SUB_CFG_ORG: begin
                            if (link.we) begin
                                cfg_nxt[bank].org = link.wdata[0];
                            end
                            rdata_nxt[0] = cfg_r[bank].org;
                        end
                        `SUB_CFG_DEF: begin
                            if (link.we) begin
                                if (ptr_equal) begin
                                    cfg_nxt[bank].def = link.wdata[0];
                                end else begin
                                    err_nxt = 1'b1;
                                end
                            end
                            rdata_nxt[0] = cfg_r[bank].def;
                        end
                        `SUB_CFG_POL: begin
                            if (link.we) begin
                                if (ptr_equal) begin
                                    cfg_nxt[bank].pol = link.wdata[0];
                                end else begin
                                    err_nxt = 1'b1;
                                end
                            end
                            rdata_nxt[0] = cfg_r[bank].pol;
                        end
                        `SUB_CFG_EOB: begin
                            if (link.we) begin
                                cfg_nxt[bank].eob = link.wdata[0];
                            end
                            rdata_nxt[0] = cfg_r[bank].eob;
                        end
                        default: begin
                            err_nxt = 1'b1;
                        end
                    endcase
                end
                `IDX_REC_FIRST, `IDX_REC_SECOND: begin
                    if (link.sub == 8'h00) begin
                        err_nxt = link.we;
                        rdata_nxt[7:0] = `RECORD_LEN;
                    end else if (!sub_in_record) begin
                        err_nxt = 1'b1;
                    end else begin
                        rdata_nxt = od_word;
                        if (link.we) begin
                            mem_we = 1'b1;
                            if (bank == sel_r) begin
                                wr_nxt = (link.sub == `RECORD_LEN) ?
                                    `PTR_INIT : link.sub + 8'h01;
                            end
                        end
                    end
                end
                `IDX_PTR_MON: begin
                    err_nxt = link.we;
                    case (link.sub)
                        8'h00: rdata_nxt = `PTR_ENTRY_COUNT;
                        `SUB_PTR_READ: rdata_nxt[7:0] = rd_r;
                        `SUB_PTR_WRITE: rdata_nxt[7:0] = wr_r;
                        default: err_nxt = 1'b1;
                    endcase
                end
                default: begin
                    err_nxt = 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // state registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sel_r <= `SEL_RESET;
            cfg_r[0] <= `CFG_FIRST_RESET;
            cfg_r[1] <= `CFG_SECOND_RESET;
            enable_r <= 1'b0;
            rd_r <= `PTR_INIT;
            wr_r <= `PTR_INIT;
            pos_r <= 32'h0000_0000;
            stb_r <= 1'b0;
            ack_r <= 1'b0;
            err_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            sel_r <= sel_nxt;
            cfg_r[0] <= cfg_nxt[0];
            cfg_r[1] <= cfg_nxt[1];
            enable_r <= enable_nxt;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            pos_r <= pos_nxt;
            stb_r <= stb_nxt;
            ack_r <= ack_nxt;
            err_r <= err_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign link.ack = ack_r;
    assign link.err = err_r;
    assign link.rdata = rdata_r;
    assign pos_ref = pos_r;
    assign pos_strobe = stb_r;
    assign interp_enabled = enable_r;
    assign read_ptr = rd_r;
    assign write_ptr = wr_r;
endmodule : interp_buffer_device

// File: src/interp_master_end.sv
`timescale 1ns/1ps
`include "interp_buf_regs.svh"

module interp_master_end
    import interp_buf_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    od_link_if.master link,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [15:0] cmd_index,
    input wire logic [7:0] cmd_sub,
    input wire logic [31:0] cmd_wdata,
    output logic cmd_ready,
    output logic resp_valid,
    output logic resp_err,
    output logic [31:0] resp_rdata
);
    master_state_t st_r;
    master_state_t st_nxt;
    logic req_r;
    logic req_nxt;
    logic we_r;
    logic we_nxt;
    logic [15:0] idx_r;
    logic [15:0] idx_nxt;
    logic [7:0] sub_r;
    logic [7:0] sub_nxt;
    logic [31:0] wd_r;
    logic [31:0] wd_nxt;
    logic rv_r;
    logic rv_nxt;
    logic re_r;
    logic re_nxt;
    logic [31:0] rd_r;
    logic [31:0] rd_nxt;
    logic en_r;
    logic en_nxt;
    logic [3:0] done_r [0:1];
    logic [3:0] done_nxt [0:1];
    logic ready_r;
    logic ready_nxt;
    logic refuse;

    // ==========================================================
    // local guards before a write goes out
    always_comb begin
        refuse = 1'b0;
        if (cmd_write && cmd_index == `IDX_PROFILE_SEL && en_r) begin
            refuse = 1'b1;
        end
        if (cmd_write && (cmd_index == `IDX_REC_FIRST || cmd_index == `IDX_REC_SECOND)
            && cmd_sub != 8'h00 && done_r[cmd_index[0]] != 4'hf) begin
            refuse = 1'b1;
        end
    end

    // ==========================================================
    // request sequencer
    always_comb begin
        st_nxt = st_r;
        req_nxt = req_r;
        we_nxt = we_r;
        idx_nxt = idx_r;
        sub_nxt = sub_r;
        wd_nxt = wd_r;
        rv_nxt = 1'b0;
        re_nxt = re_r;
        rd_nxt = rd_r;
        en_nxt = en_r;
        done_nxt[0] = done_r[0];
        done_nxt[1] = done_r[1];
        case (st_r)
            M_IDLE: begin
                if (cmd_valid) begin
                    we_nxt = cmd_write;
                    idx_nxt = cmd_index;
                    sub_nxt = cmd_sub;
                    wd_nxt = cmd_wdata;
                    if (refuse) begin
                        st_nxt = M_REFUSE;
                    end else begin
                        req_nxt = 1'b1;
                        st_nxt = M_WAIT;
                    end
                end
            end
            M_WAIT: begin
                if (link.ack) begin
                    req_nxt = 1'b0;
                    rv_nxt = 1'b1;
                    re_nxt = link.err;
                    rd_nxt = link.rdata;
                    st_nxt = M_IDLE;
                    if (we_r && !link.err) begin
                        if (idx_r == `IDX_CTRL_WORD) begin
                            en_nxt = wd_r[`BIT_ENABLE_INTERP];
                        end
                        if (idx_r == `IDX_CFG_FIRST || idx_r == `IDX_CFG_SECOND) begin
                            case (sub_r)
                                `SUB_CFG_ORG: done_nxt[idx_r[0]][0] = 1'b1;
                                `SUB_CFG_DEF: done_nxt[idx_r[0]][1] = 1'b1;
                                `SUB_CFG_POL: done_nxt[idx_r[0]][2] = 1'b1;
                                `SUB_CFG_EOB: done_nxt[idx_r[0]][3] = 1'b1;
                                default: done_nxt[idx_r[0]] = done_r[idx_r[0]];
                            endcase
                        end
                    end
                end
            end
            M_REFUSE: begin
                rv_nxt = 1'b1;
                re_nxt = 1'b1;
                rd_nxt = 32'h0000_0000;
                st_nxt = M_IDLE;
            end
            default: begin
                st_nxt = M_IDLE;
                req_nxt = 1'b0;
            end
        endcase
        ready_nxt = (st_nxt == M_IDLE);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= M_IDLE;
            ready_r <= 1'b1;
            req_r <= 1'b0;
            we_r <= 1'b0;
            idx_r <= 16'h0000;
            sub_r <= 8'h00;
            wd_r <= 32'h0000_0000;
            rv_r <= 1'b0;
            re_r <= 1'b0;
            rd_r <= 32'h0000_0000;
            en_r <= 1'b0;
            done_r[0] <= 4'h0;
            done_r[1] <= 4'h0;
        end else begin
            st_r <= st_nxt;
            ready_r <= ready_nxt;
            req_r <= req_nxt;
            we_r <= we_nxt;
            idx_r <= idx_nxt;
            sub_r <= sub_nxt;
            wd_r <= wd_nxt;
            rv_r <= rv_nxt;
            re_r <= re_nxt;
            rd_r <= rd_nxt;
            en_r <= en_nxt;
            done_r[0] <= done_nxt[0];
            done_r[1] <= done_nxt[1];
        end
    end

    assign cmd_ready = ready_r;
    assign link.req = req_r;
    assign link.we = we_r;
    assign link.index = idx_r;
    assign link.sub = sub_r;
    assign link.wdata = wd_r;
    assign resp_valid = rv_r;
    assign resp_err = re_r;
    assign resp_rdata = rd_r;
endmodule : interp_master_end

// File: test/interp_reference_buffer_props.sv
`timescale 1ns/1ps
`include "interp_buf_regs.svh"

module interp_reference_buffer_props
    import interp_buf_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic req,
    input wire logic we,
    input wire logic [15:0] index,
    input wire logic [7:0] sub,
    input wire logic [31:0] wdata,
    input wire logic ack,
    input wire logic err,
    input wire logic [31:0] rdata
);
    // ==========================================================
    // handshake steps
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic is_rec;
    assign is_rec = (index == `IDX_REC_FIRST) || (index == `IDX_REC_SECOND);

    sequence s_taken;
        req && !ack;
    endsequence
    sequence s_answer;
        ack ##1 !ack;
    endsequence

    // ==========================================================
    // link timing and object map
    AST_ACK_AFTER_TAKE: assert property (s_taken |=> s_answer)
        else $error("ack not one cycle after request");
    AST_REQ_HELD: assert property (s_taken |=> req && $stable(index) && $stable(sub)
        && $stable(we) && $stable(wdata)) else $error("request changed before ack");
    AST_REQ_DROP: assert property (ack |=> !req)
        else $error("request not dropped after ack");
    AST_PTR_RO: assert property (ack && we && index == `IDX_PTR_MON |-> err)
        else $error("pointer monitor write not refused");
    AST_PTR_RANGE: assert property (ack && !we && index == `IDX_PTR_MON
        && sub inside {8'h01, 8'h02} |-> !err && rdata >= 32'h1 && rdata <= 32'hfe)
        else $error("pointer out of range");
    AST_REC_COUNT: assert property (ack && !we && is_rec && sub == 8'h00
        |-> !err && rdata == 32'h0000_00fe) else $error("record count wrong");
    AST_REC_SUB_RANGE: assert property (ack && is_rec && sub == 8'hff |-> err)
        else $error("record sub-index 255 accepted");
    AST_SEL_RANGE: assert property (ack && we && index == `IDX_PROFILE_SEL
        && wdata > 32'h1 |-> err) else $error("selector above 1 accepted");
    AST_SEL_READ: assert property (ack && !we && index == `IDX_PROFILE_SEL
        |-> !err && rdata <= 32'h1) else $error("selector reads above 1");
endmodule : interp_reference_buffer_props

// File: test/test_interp_reference_buffer.sv
`timescale 1ns/1ps
`include "interp_buf_regs.svh"

module test_interp_reference_buffer
    import interp_buf_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cycle_tick = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [15:0] cmd_index = 16'h0000;
    logic [7:0] cmd_sub = 8'h00;
    logic [31:0] cmd_wdata = 32'h0000_0000;
    logic cmd_ready, resp_valid, resp_err, pos_strobe, interp_enabled;
    logic [31:0] resp_rdata, pos_ref, expv;
    logic [7:0] read_ptr, write_ptr;
    logic [31:0] vals [4] = '{32'h0000_0064, 32'hffff_fffb, 32'h0000_0007, 32'h0000_0003};
    int num_errors = 0;
    int comparisons = 0;

    always #4 clk = ~clk;

    od_link_if link();
    interp_buffer_device u_interp_buffer_device (.clk(clk), .reset(reset), .link(link),
        .cycle_tick(cycle_tick), .pos_ref(pos_ref), .pos_strobe(pos_strobe),
        .interp_enabled(interp_enabled), .read_ptr(read_ptr), .write_ptr(write_ptr));
    interp_master_end u_interp_master_end (.clk(clk), .reset(reset), .link(link),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_index(cmd_index),
        .cmd_sub(cmd_sub), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .resp_valid(resp_valid), .resp_err(resp_err), .resp_rdata(resp_rdata));
    interp_reference_buffer_props u_checker (.clk(clk), .reset(reset), .req(link.req),
        .we(link.we), .index(link.index), .sub(link.sub), .wdata(link.wdata),
        .ack(link.ack), .err(link.err), .rdata(link.rdata));

    // ==========================================================
    // checking and access tasks
    task automatic finish_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic op(input logic w, input logic [15:0] idx, input logic [7:0] sb,
        input logic [31:0] d, input logic exp_err);
        int n;
        n = 0;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_index = idx;
        cmd_sub = sb;
        cmd_wdata = d;
        @(negedge clk);
        cmd_valid = 1'b0;
        n = 0;
        while (resp_valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk($sformatf("obj %h.%h response", idx, sb), 32'h1, {31'h0, resp_valid});
        chk($sformatf("obj %h.%h err", idx, sb), {31'h0, exp_err}, {31'h0, resp_err});
        if (!w && !exp_err) begin
            chk($sformatf("obj %h.%h data", idx, sb), d, resp_rdata);
        end
    endtask : op

    // pulse one consume request and watch for the new reference
    task automatic tick(input logic exp_s, input logic [31:0] exp_ref);
        logic seen;
        seen = 1'b0;
        @(negedge clk);
        cycle_tick = 1'b1;
        repeat (3) begin
            @(negedge clk);
            cycle_tick = 1'b0;
            seen = seen | (pos_strobe === 1'b1);
        end
        chk("pos_strobe", {31'h0, exp_s}, {31'h0, seen});
        if (exp_s) begin
            chk("pos_ref", exp_ref, pos_ref);
        end
    endtask : tick

    // ==========================================================
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        finish_test();
    end

    // ==========================================================
    // scenarios
    initial begin
        repeat (5) @(negedge clk);
        reset = 1'b0;
        op(0, `IDX_PROFILE_SEL, 8'h00, 32'h0, 0);
        op(0, `IDX_CFG_FIRST, `SUB_CFG_DEF, 32'h1, 0);
        op(0, `IDX_CFG_SECOND, `SUB_CFG_DEF, 32'h0, 0);
        op(0, `IDX_PTR_MON, `SUB_PTR_READ, 32'h1, 0);
        op(0, `IDX_PTR_MON, `SUB_PTR_WRITE, 32'h1, 0);
        op(0, `IDX_REC_FIRST, 8'h00, 32'hfe, 0);
        op(0, `IDX_REC_SECOND, 8'hfe, 32'h0, 0);
        op(0, `IDX_CFG_FIRST, `SUB_CFG_MAX_SIZE, 32'hfe, 0);
        op(0, `IDX_CFG_SECOND, `SUB_CFG_COUNT, 32'h9, 0);
        op(0, `IDX_REC_FIRST, 8'hff, 32'h0, 1);
        op(0, 16'h1234, 8'h00, 32'h0, 1);
        op(1, `IDX_PTR_MON, `SUB_PTR_READ, 32'h5, 1);
        op(1, `IDX_PROFILE_SEL, 8'h00, 32'h2, 1);
        op(1, `IDX_REC_FIRST, 8'h00, 32'h5, 1);
        op(1, `IDX_REC_FIRST, 8'h01, vals[0], 1);
        op(1, `IDX_CFG_FIRST, `SUB_CFG_ORG, 32'h0, 0);
        op(1, `IDX_CFG_FIRST, `SUB_CFG_DEF, 32'h0, 0);
        op(1, `IDX_CFG_FIRST, `SUB_CFG_POL, 32'h1, 0);
        op(1, `IDX_CFG_FIRST, `SUB_CFG_EOB, 32'h0, 0);
        for (int i = 0; i < 2; i++) begin
            op(1, `IDX_REC_FIRST, 8'(i + 1), vals[i], 0);
        end
        op(0, `IDX_PTR_MON, `SUB_PTR_WRITE, 32'h3, 0);
        op(1, `IDX_CFG_FIRST, `SUB_CFG_DEF, 32'h1, 1);
        op(0, `IDX_CFG_FIRST, `SUB_CFG_DEF, 32'h0, 0);
        op(1, `IDX_CTRL_WORD, 8'h00, 32'h10, 0);
        chk("interp_enabled", 32'h1, {31'h0, interp_enabled});
        tick(1, vals[0]);
        tick(1, vals[1]);
        tick(0, 32'h0);
        op(1, `IDX_CTRL_WORD, 8'h00, 32'h0, 0);
        op(1, `IDX_CFG_FIRST, `SUB_CFG_DEF, 32'h1, 0);
        for (int i = 2; i < 4; i++) begin
            op(1, `IDX_REC_FIRST, 8'(i + 1), vals[i], 0);
        end
        op(1, `IDX_CTRL_WORD, 8'h00, 32'h10, 0);
        expv = vals[1];
        for (int i = 2; i < 4; i++) begin
            expv = expv - vals[i];
            tick(1, expv);
            op(0, `IDX_PTR_MON, `SUB_PTR_READ, 32'(i + 2), 0);
        end
        op(1, `IDX_CTRL_WORD, 8'h00, 32'h0, 0);
        op(0, `IDX_PTR_MON, `SUB_PTR_READ, 32'h5, 0);
        chk("read_ptr", 32'h5, {24'h0, read_ptr});
        chk("write_ptr", 32'h5, {24'h0, write_ptr});
        op(1, `IDX_CFG_FIRST, `SUB_CFG_EOB, 32'h1, 0);
        op(0, `IDX_PTR_MON, `SUB_PTR_READ, 32'h1, 0);
        op(1, `IDX_CFG_FIRST, `SUB_CFG_ORG, 32'h1, 0);
        op(1, `IDX_CTRL_WORD, 8'h00, 32'h10, 0);
        for (int i = 0; i < 4; i++) begin
            expv = expv - vals[i];
            tick(1, expv);
        end
        @(negedge clk);
        cycle_tick = 1'b1;
        @(negedge clk);
        cycle_tick = 1'b0;
        op(0, `IDX_PTR_MON, `SUB_PTR_READ, 32'h1, 0);
        for (int i = 0; i < 4; i++) begin
            expv = expv - vals[i];
            tick(1, expv);
        end
        op(1, `IDX_PROFILE_SEL, 8'h00, 32'h1, 1);
        op(1, `IDX_CTRL_WORD, 8'h00, 32'h0, 0);
        op(1, `IDX_PROFILE_SEL, 8'h00, 32'h1, 0);
        op(0, `IDX_PROFILE_SEL, 8'h00, 32'h1, 0);
        op(1, `IDX_CFG_SECOND, `SUB_CFG_ORG, 32'h0, 0);
        op(1, `IDX_CFG_SECOND, `SUB_CFG_DEF, 32'h0, 0);
        op(1, `IDX_CFG_SECOND, `SUB_CFG_POL, 32'h0, 0);
        op(1, `IDX_CFG_SECOND, `SUB_CFG_EOB, 32'h1, 0);
        op(0, `IDX_PTR_MON, `SUB_PTR_READ, 32'h1, 0);
        op(1, `IDX_REC_SECOND, 8'h01, 32'h0000_002a, 0);
        op(1, `IDX_CTRL_WORD, 8'h00, 32'h10, 0);
        tick(1, 32'h0000_002a);
        finish_test();
    end
endmodule : test_interp_reference_buffer
